// ===== scac_adjust_chain.v
// compatible tuning chain: feedforward, P/PI mode switch, force reference filters
//
// Behaviour
// [RQ1] feedforward added to position control, gain 0..100 percent, default 0, immediate.
// [RQ2] feedforward smoothed by first-order filter, 0..6400 x 0.01 ms, default 0.
// [RQ3] configurer should keep feedforward gain at or below 80 percent.
// [RQ4] speed loop switches automatically between P and PI by condition and threshold.
// [RQ5] condition digit: 0 force, 1 speed, 2 accel, 3 position error, 4 off.
// [RQ6] force condition: P while force reference exceeds 0..800 percent threshold, default 200.
// [RQ7] speed condition: P while speed reference exceeds 0..10000 mm/s threshold.
// [RQ8] accel condition: P while speed-reference derivative exceeds 0..30000 mm/s2.
// [RQ9] position error condition: P while error exceeds 0..10000 reference units.
// [RQ10] position error condition acts only under position control.
// [RQ11] force reference passes lag and notch stages in series, each independent.
// [RQ12] lag time constant 0..65535 x 0.01 ms, default 100, immediate.
// [RQ13] configurer should keep lag tc below 1000/(2pi x speed gain x 4) ms.
// [RQ14] second-step filter frequency 100..5000 Hz, default 5000; 5000 bypasses it.
// [RQ15] second-step filter Q 50..100 x 0.01, default 50, immediate.
// [RQ16] notch stages enabled or bypassed by notch enable setting.
// [RQ17] digit 0 = 1 enables notch 1, digit 2 = 1 enables notch 2; default off.
// [RQ18] PI control returns as soon as quantity no longer exceeds threshold.
`timescale 1ns/1ps
`include "scac_consts.vh"

// second-order state-variable stage: low-pass or notch, bypassed when en is low
module scac_svf (
  // clock and reset
  input wire sys_clk,
  input wire rst_n,
  // control
  input wire tick,
  input wire en,
  input wire notch_sel,
  input wire [15:0] freq,
  input wire [15:0] q,
  // data
  input wire signed [31:0] x,
  output reg signed [31:0] y
);
  reg signed [31:0] low_r;
  reg signed [31:0] band_r;
  wire signed [47:0] w_coef;
  wire signed [47:0] damp;
  wire signed [47:0] low_nxt;
  wire signed [47:0] high;
  wire signed [47:0] band_nxt;
  wire [47:0] damp_u;

  // coefficients in Q16: w = 2*pi*f*Ts, damping term = 1/Q
  assign w_coef = $signed(({32'h00000000, freq} * 48'd`SCAC_W_PER_HZ) >> 12);
  assign damp_u = 48'd`SCAC_DAMP_NUM / {32'h00000000, q};
  assign damp = $signed(damp_u);
  assign low_nxt = low_r + ((w_coef * band_r) >>> 16);
  assign high = x - low_nxt - ((damp * band_r) >>> 16);
  assign band_nxt = band_r + ((w_coef * high) >>> 16);

  always @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      low_r <= 32'sh00000000;
      band_r <= 32'sh00000000;
      y <= 32'sh00000000;
    end else if (tick) begin
      if (en) begin
        low_r <= low_nxt[31:0];
        band_r <= band_nxt[31:0];
        // notch: input less the damped band-pass part
        y <= notch_sel ? high[31:0] + low_nxt[31:0] : low_nxt[31:0];
      end else begin
        // bypassed stage keeps no history so re-enabling starts clean
        low_r <= 32'sh00000000;
        band_r <= 32'sh00000000;
        y <= x;
      end
    end
  end
endmodule // scac_svf

module scac_adjust_chain (
  // clock and reset
  input wire sys_clk,
  input wire rst_n,
  // avalon-mm slave
  input wire [7:0] avs_address,
  input wire avs_read,
  input wire avs_write,
  input wire [31:0] avs_writedata,
  input wire [3:0] avs_byteenable,
  output reg [31:0] avs_readdata,
  output reg avs_waitrequest,
  // loop quantities, sampled on the control tick
  input wire pos_ctrl_mode,
  input wire signed [31:0] pos_ref_speed,
  input wire signed [31:0] speed_ref,
  input wire signed [31:0] force_ref_in,
  input wire signed [31:0] pos_err,
  // results
  output reg signed [31:0] ff_term,
  output reg p_only,
  output wire signed [31:0] force_ref_out,
  output reg ctrl_tick
);
  reg [15:0] ff_gain_r;
  reg [15:0] ff_filter_tc_r;
  reg [15:0] gain_app_select_r;
  reg [15:0] ms_force_thr_r;
  reg [15:0] ms_speed_thr_r;
  reg [15:0] ms_accel_thr_r;
  reg [15:0] ms_poserr_thr_r;
  reg [15:0] force_lag_tc_r;
  reg [15:0] second_lpf_freq_r;
  reg [15:0] second_lpf_q_r;
  reg [15:0] notch_enable_cfg_r;
  reg [9:0] div_r;
  reg signed [31:0] ff_raw_r;
  reg signed [31:0] speed_prev_r;
  reg signed [31:0] lag_r;
  reg [31:0] rdata_nxt;
  reg p_only_nxt;
  wire req;
  wire take;
  wire [15:0] wdata;
  wire [3:0] ms_cond;
  wire [1:0] notch_en;
  wire [31:0] abs_force;
  wire [31:0] abs_speed;
  wire [31:0] abs_err;
  wire [31:0] abs_dspeed;
  wire signed [31:0] dspeed;
  wire [47:0] accel;
  wire signed [47:0] ff_scaled;
  wire signed [31:0] ff_step;
  wire signed [31:0] lag_step;
  wire signed [31:0] lpf_out;
  wire signed [31:0] notch_io [0:2];

  function [15:0] clamp;
    input [15:0] v;
    input [15:0] lo;
    input [15:0] hi;
    begin
      clamp = (v < lo) ? lo : ((v > hi) ? hi : v);
    end
  endfunction

  function [31:0] mag;
    input [31:0] v;
    begin
      mag = v[31] ? (32'h00000000 - v) : v;
    end
  endfunction

  // control-cycle enable: one pulse per control cycle;
  // loop inputs are sampled and loop state moves only while it is high
  always @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      div_r <= 10'h000;
      ctrl_tick <= 1'b0;
    end else if (div_r == `SCAC_CTRL_CYCLES - 1) begin
      div_r <= 10'h000;
      ctrl_tick <= 1'b1;
    end else begin
      div_r <= div_r + 10'h001;
      ctrl_tick <= 1'b0;
    end
  end

  // bus: one wait cycle, then the access completes; waitrequest idles high
  // so a request is always held through its taking edge and released after the next
  assign req = avs_read | avs_write;
  assign take = req & avs_waitrequest;
  assign wdata = {avs_byteenable[1] ? avs_writedata[15:8] : 8'h00,
    avs_byteenable[0] ? avs_writedata[7:0] : 8'h00};

  // read mux; status holds p_only in bit 0 and any notch on in bit 1
  always @* begin
    case (avs_address & 8'hfc)
      `SCAC_OFS_FF_GAIN: rdata_nxt = {16'h0000, ff_gain_r};
      `SCAC_OFS_FF_FILTER_TC: rdata_nxt = {16'h0000, ff_filter_tc_r};
      `SCAC_OFS_GAIN_APP_SELECT: rdata_nxt = {16'h0000, gain_app_select_r};
      `SCAC_OFS_MS_FORCE_THR: rdata_nxt = {16'h0000, ms_force_thr_r};
      `SCAC_OFS_MS_SPEED_THR: rdata_nxt = {16'h0000, ms_speed_thr_r};
      `SCAC_OFS_MS_ACCEL_THR: rdata_nxt = {16'h0000, ms_accel_thr_r};
      `SCAC_OFS_MS_POSERR_THR: rdata_nxt = {16'h0000, ms_poserr_thr_r};
      `SCAC_OFS_FORCE_LAG_TC: rdata_nxt = {16'h0000, force_lag_tc_r};
      `SCAC_OFS_SECOND_LPF_FREQ: rdata_nxt = {16'h0000, second_lpf_freq_r};
      `SCAC_OFS_SECOND_LPF_Q: rdata_nxt = {16'h0000, second_lpf_q_r};
      `SCAC_OFS_NOTCH_ENABLE_CFG: rdata_nxt = {16'h0000, notch_enable_cfg_r};
      `SCAC_OFS_STATUS: rdata_nxt = {30'h00000000, notch_en[0] | notch_en[1], p_only};
      default: rdata_nxt = 32'h00000000;
    endcase
  end

  always @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      avs_waitrequest <= 1'b1;
      avs_readdata <= 32'h00000000;
    end else begin
      avs_waitrequest <= ~take;
      // read data is captured on the taking edge so it stands while waitrequest is low
      if (take && avs_read) begin
        avs_readdata <= rdata_nxt;
      end
    end
  end

  // settings take effect at the completing edge; out-of-range writes are clamped
  // only bits 15:0 of the write word carry a setting
  always @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      ff_gain_r <= `SCAC_RST_FF_GAIN;
      ff_filter_tc_r <= `SCAC_RST_FF_FILTER_TC;
      gain_app_select_r <= `SCAC_RST_GAIN_APP_SELECT;
      ms_force_thr_r <= `SCAC_RST_MS_FORCE_THR;
      ms_speed_thr_r <= `SCAC_RST_MS_SPEED_THR;
      ms_accel_thr_r <= `SCAC_RST_MS_ACCEL_THR;
      ms_poserr_thr_r <= `SCAC_RST_MS_POSERR_THR;
      force_lag_tc_r <= `SCAC_RST_FORCE_LAG_TC;
      second_lpf_freq_r <= `SCAC_RST_SECOND_LPF_FREQ;
      second_lpf_q_r <= `SCAC_RST_SECOND_LPF_Q;
      notch_enable_cfg_r <= `SCAC_RST_NOTCH_ENABLE_CFG;
    end else if (avs_write && !avs_waitrequest) begin
      case (avs_address & 8'hfc)
        `SCAC_OFS_FF_GAIN: ff_gain_r <= clamp(wdata, 16'h0000, `SCAC_MAX_FF_GAIN); // [RQ1]
        `SCAC_OFS_FF_FILTER_TC: ff_filter_tc_r <= clamp(wdata, 16'h0000,
          `SCAC_MAX_FF_FILTER_TC); // [RQ2]
        `SCAC_OFS_GAIN_APP_SELECT: gain_app_select_r <= wdata; // [RQ5]
        `SCAC_OFS_MS_FORCE_THR: ms_force_thr_r <= clamp(wdata, 16'h0000,
          `SCAC_MAX_MS_FORCE_THR); // [RQ6]
        `SCAC_OFS_MS_SPEED_THR: ms_speed_thr_r <= clamp(wdata, 16'h0000,
          `SCAC_MAX_MS_SPEED_THR); // [RQ7]
        `SCAC_OFS_MS_ACCEL_THR: ms_accel_thr_r <= clamp(wdata, 16'h0000,
          `SCAC_MAX_MS_ACCEL_THR); // [RQ8]
        `SCAC_OFS_MS_POSERR_THR: ms_poserr_thr_r <= clamp(wdata, 16'h0000,
          `SCAC_MAX_MS_POSERR_THR); // [RQ9]
        `SCAC_OFS_FORCE_LAG_TC: force_lag_tc_r <= wdata; // [RQ12]
        `SCAC_OFS_SECOND_LPF_FREQ: second_lpf_freq_r <= clamp(wdata,
          `SCAC_MIN_SECOND_LPF_FREQ, `SCAC_MAX_SECOND_LPF_FREQ); // [RQ14]
        `SCAC_OFS_SECOND_LPF_Q: second_lpf_q_r <= clamp(wdata,
          `SCAC_MIN_SECOND_LPF_Q, `SCAC_MAX_SECOND_LPF_Q); // [RQ15]
        `SCAC_OFS_NOTCH_ENABLE_CFG: notch_enable_cfg_r <= wdata; // [RQ16]
        default: ;
      endcase
    end
  end

  // feedforward: gain in percent, then first-order smoothing y += (x - y)/(tc + 1)
  assign ff_scaled = (pos_ref_speed * $signed({32'h00000000, ff_gain_r})) / 48'sd100; // [RQ1]
  // integer steps stall once |x - y| is below tc + 1, so a small residual may remain
  assign ff_step = (ff_raw_r - ff_term) / $signed({16'h0000, ff_filter_tc_r} + 32'sd1); // [RQ2]

  always @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      ff_raw_r <= 32'sh00000000;
      ff_term <= 32'sh00000000;
    end else if (ctrl_tick) begin
      ff_raw_r <= ff_scaled[31:0];
      ff_term <= ff_term + ff_step; // [RQ2]
    end
  end

  // mode switch; codes 4 to 15 leave the speed loop in PI
  assign ms_cond = gain_app_select_r[`SCAC_MS_COND_LSB +: 4];
  assign abs_force = mag(force_ref_in);
  assign abs_speed = mag(speed_ref);
  assign abs_err = mag(pos_err);
  assign dspeed = speed_ref - speed_prev_r;
  assign abs_dspeed = mag(dspeed);
  // acceleration: speed change per control cycle scaled to per second
  assign accel = {16'h0000, abs_dspeed} * `SCAC_CTRL_PER_S;

  always @* begin
    case (ms_cond) // [RQ5]
      `SCAC_MS_FORCE: p_only_nxt = abs_force > {16'h0000, ms_force_thr_r}; // [RQ6]
      `SCAC_MS_SPEED: p_only_nxt = abs_speed > {16'h0000, ms_speed_thr_r}; // [RQ7]
      `SCAC_MS_ACCEL: p_only_nxt = accel > {32'h00000000, ms_accel_thr_r}; // [RQ8]
      // position error only counts while the position loop is in charge
      `SCAC_MS_POSERR: p_only_nxt = pos_ctrl_mode
        && (abs_err > {16'h0000, ms_poserr_thr_r}); // [RQ9] [RQ10]
      default: p_only_nxt = 1'b0;
    endcase
  end

  // p_only is re-evaluated every tick, so PI returns as soon as the level drops
  always @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      speed_prev_r <= 32'sh00000000;
      p_only <= 1'b0;
    end else if (ctrl_tick) begin
      speed_prev_r <= speed_ref;
      p_only <= p_only_nxt; // [RQ4] [RQ18]
    end
  end

  // force chain: lag, second-step low-pass, two notches, each its own registered stage
  // every stage adds one control cycle of delay, bypassed or not, except the enabled low-pass, which adds two
  // the lag uses the same first-order form as the feedforward smoothing
  assign lag_step = (force_ref_in - lag_r) / $signed({16'h0000, force_lag_tc_r} + 32'sd1);

  always @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      lag_r <= 32'sh00000000;
    end else if (ctrl_tick) begin
      lag_r <= lag_r + lag_step; // [RQ11] [RQ12]
    end
  end

  scac_svf u_lpf (
    .sys_clk(sys_clk),
    .rst_n(rst_n),
    .tick(ctrl_tick),
    .en(second_lpf_freq_r != `SCAC_MAX_SECOND_LPF_FREQ), // [RQ14]
    .notch_sel(1'b0),
    .freq(second_lpf_freq_r),
    .q(second_lpf_q_r), // [RQ15]
    .x(lag_r),
    .y(lpf_out)
  );

  // notch digits are nibbles: bits 3:0 for the first stage, 11:8 for the second
  assign notch_en[0] = notch_enable_cfg_r[`SCAC_NOTCH1_LSB +: 4] == 4'h1; // [RQ17]
  assign notch_en[1] = notch_enable_cfg_r[`SCAC_NOTCH2_LSB +: 4] == 4'h1; // [RQ17]
  assign notch_io[0] = lpf_out;

  genvar gi;
  generate
    for (gi = 0; gi < 2; gi = gi + 1) begin : g_notch
      scac_svf u_notch (
        .sys_clk(sys_clk),
        .rst_n(rst_n),
        .tick(ctrl_tick),
        .en(notch_en[gi]), // [RQ16] [RQ11]
        .notch_sel(1'b1),
        .freq(`SCAC_NOTCH_FREQ),
        .q(`SCAC_NOTCH_Q),
        .x(notch_io[gi]),
        .y(notch_io[gi + 1])
      );
    end
  endgenerate

  assign force_ref_out = notch_io[2];
endmodule // scac_adjust_chain

// ===== scac_consts.vh
// constants for the compatible tuning chain: register map, resets, ranges, timing
`ifndef SCAC_CONSTS_VH
`define SCAC_CONSTS_VH
// byte offsets on the register bus
`define SCAC_OFS_FF_GAIN 8'h00
`define SCAC_OFS_FF_FILTER_TC 8'h04
`define SCAC_OFS_GAIN_APP_SELECT 8'h08
`define SCAC_OFS_MS_FORCE_THR 8'h0c
`define SCAC_OFS_MS_SPEED_THR 8'h10
`define SCAC_OFS_MS_ACCEL_THR 8'h14
`define SCAC_OFS_MS_POSERR_THR 8'h18
`define SCAC_OFS_FORCE_LAG_TC 8'h1c
`define SCAC_OFS_SECOND_LPF_FREQ 8'h20
`define SCAC_OFS_SECOND_LPF_Q 8'h24
`define SCAC_OFS_NOTCH_ENABLE_CFG 8'h28
`define SCAC_OFS_STATUS 8'h2c
// reset values
`define SCAC_RST_FF_GAIN 16'h0000
`define SCAC_RST_FF_FILTER_TC 16'h0000
`define SCAC_RST_GAIN_APP_SELECT 16'h0000
`define SCAC_RST_MS_FORCE_THR 16'h00c8
`define SCAC_RST_MS_SPEED_THR 16'h0000
`define SCAC_RST_MS_ACCEL_THR 16'h0000
`define SCAC_RST_MS_POSERR_THR 16'h0000
`define SCAC_RST_FORCE_LAG_TC 16'h0064
`define SCAC_RST_SECOND_LPF_FREQ 16'h1388
`define SCAC_RST_SECOND_LPF_Q 16'h0032
`define SCAC_RST_NOTCH_ENABLE_CFG 16'h0000
// setting ranges
`define SCAC_MAX_FF_GAIN 16'h0064
`define SCAC_MAX_FF_FILTER_TC 16'h1900
`define SCAC_MAX_MS_FORCE_THR 16'h0320
`define SCAC_MAX_MS_SPEED_THR 16'h2710
`define SCAC_MAX_MS_ACCEL_THR 16'h7530
`define SCAC_MAX_MS_POSERR_THR 16'h2710
`define SCAC_MIN_SECOND_LPF_FREQ 16'h0064
`define SCAC_MAX_SECOND_LPF_FREQ 16'h1388
`define SCAC_MIN_SECOND_LPF_Q 16'h0032
`define SCAC_MAX_SECOND_LPF_Q 16'h0064
// field positions
`define SCAC_MS_COND_LSB 0
`define SCAC_NOTCH1_LSB 0
`define SCAC_NOTCH2_LSB 8
// mode switch condition codes
`define SCAC_MS_FORCE 4'h0
`define SCAC_MS_SPEED 4'h1
`define SCAC_MS_ACCEL 4'h2
`define SCAC_MS_POSERR 4'h3
// fixed notch tuning (frequency in Hz, Q in 0.01)
`define SCAC_NOTCH_FREQ 16'h1388
`define SCAC_NOTCH_Q 16'h0046
// timing: control cycle equals one filter time-constant unit of 0.01 ms
`define SCAC_CLK_PERIOD_NS 20
`define SCAC_CTRL_PERIOD_NS 10000
`define SCAC_CTRL_CYCLES (`SCAC_CTRL_PERIOD_NS / `SCAC_CLK_PERIOD_NS)
`define SCAC_CTRL_PER_S (48'd1000000000 / `SCAC_CTRL_PERIOD_NS)
// 2*pi*Ts scaled by 2^28, and 1/Q scale (Q16 with Q in 0.01)
`define SCAC_W_PER_HZ 16865
`define SCAC_DAMP_NUM 6553600
`endif

// ===== scac_chain_props.sv
// assertion checker watching the ports of the compatible tuning chain
`timescale 1ns/1ps
module scac_chain_props (
  // clock and reset
  input wire sys_clk,
  input wire rst_n,
  // register bus
  input wire [7:0] avs_address,
  input wire avs_read,
  input wire avs_write,
  input wire [31:0] avs_readdata,
  input wire avs_waitrequest,
  // loop results
  input wire signed [31:0] ff_term,
  input wire p_only,
  input wire signed [31:0] force_ref_out,
  input wire ctrl_tick
);
  reg [9:0] cnt_r;
  // starts at all ones: it trails div_r by one edge, so the first control period is also 500 edges
  always @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n)
      cnt_r <= 10'h3ff;
    else
      cnt_r <= ctrl_tick ? 10'h000 : cnt_r + 10'h001;
  end
  default clocking @(posedge sys_clk); endclocking
  default disable iff (!rst_n);
  ack_next_a: assert property ((avs_read || avs_write) && avs_waitrequest |=> !avs_waitrequest)
    else $error("bus request not answered in the next cycle");
  ack_single_a: assert property (!avs_waitrequest |=> avs_waitrequest)
    else $error("waitrequest low for more than one cycle");
  rd_upper_a: assert property (avs_read && !avs_waitrequest |-> avs_readdata[31:16] == 16'h0000)
    else $error("read data upper half not zero");
  rd_hold_a: assert property ($changed(avs_readdata) |-> avs_read && !avs_waitrequest)
    else $error("read data moved outside a read");
  tick_period_a: assert property (ctrl_tick == (cnt_r == 10'h1f3))
    else $error("control tick not every 500 clocks");
  mode_on_tick_a: assert property ($changed(p_only) |-> $past(ctrl_tick))
    else $error("p_only changed away from a control tick");
  ff_on_tick_a: assert property ($changed(ff_term) |-> $past(ctrl_tick))
    else $error("ff_term changed away from a control tick");
  force_on_tick_a: assert property ($changed(force_ref_out) |-> $past(ctrl_tick))
    else $error("force output changed away from a control tick");
  status_mode_a: assert property (avs_read && !avs_waitrequest && avs_address == 8'h2c
    |-> avs_readdata[0] == $past(p_only))
    else $error("status bit does not follow p_only");
endmodule // scac_chain_props

// ===== scac_ctrl_model.sv
// motion controller model presenting references once per control tick
`timescale 1ns/1ps
module scac_ctrl_model (
  // clock and reset
  input wire sys_clk,
  input wire rst_n,
  input wire ctrl_tick,
  // commands from the bench
  input wire cmd_mode,
  input wire signed [31:0] cmd_speed,
  input wire signed [31:0] cmd_step,
  input wire signed [31:0] cmd_force,
  input wire signed [31:0] cmd_err,
  input wire signed [31:0] cmd_ff,
  // references to the drive
  output reg pos_ctrl_mode,
  output reg signed [31:0] pos_ref_speed,
  output reg signed [31:0] speed_ref,
  output reg signed [31:0] force_ref_in,
  output reg signed [31:0] pos_err
);
  // new values right after a tick, so they stand through the next one
  always @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      pos_ctrl_mode <= 1'b0;
      pos_ref_speed <= 32'sh0;
      speed_ref <= 32'sh0;
      force_ref_in <= 32'sh0;
      pos_err <= 32'sh0;
    end else if (ctrl_tick) begin
      pos_ctrl_mode <= cmd_mode;
      pos_ref_speed <= cmd_ff;
      // a nonzero step ramps the speed to produce acceleration
      speed_ref <= (cmd_step != 0) ? speed_ref + cmd_step : cmd_speed;
      force_ref_in <= cmd_force;
      pos_err <= cmd_err;
    end
  end
endmodule // scac_ctrl_model

// ===== scac_adjust_chain_tb.sv
// self-checking bench for the compatible tuning chain
`timescale 1ns/1ps
`include "scac_consts.vh"
module scac_adjust_chain_tb;
  reg sys_clk = 1'b0;
  reg rst_n = 1'b0;
  reg [7:0] avs_address = 8'h00;
  reg avs_read = 1'b0;
  reg avs_write = 1'b0;
  reg [31:0] avs_writedata = 32'h0;
  reg [3:0] avs_byteenable = 4'hf;
  reg cmd_mode = 1'b0;
  reg signed [31:0] cmd_speed = 0, cmd_step = 0, cmd_force = 0, cmd_err = 0, cmd_ff = 0;
  wire [31:0] avs_readdata;
  wire avs_waitrequest, pos_ctrl_mode, p_only, ctrl_tick;
  wire signed [31:0] pos_ref_speed, speed_ref, force_ref_in, pos_err, ff_term, force_ref_out;
  logic [15:0] lo_v [11], hi_v [11], rst_v [11];
  int n_errors = 0;
  int compares = 0;
  always #10 sys_clk = ~sys_clk;
  scac_adjust_chain dut_u (.sys_clk(sys_clk), .rst_n(rst_n), .avs_address(avs_address),
    .avs_read(avs_read), .avs_write(avs_write), .avs_writedata(avs_writedata),
    .avs_byteenable(avs_byteenable), .avs_readdata(avs_readdata),
    .avs_waitrequest(avs_waitrequest), .pos_ctrl_mode(pos_ctrl_mode),
    .pos_ref_speed(pos_ref_speed), .speed_ref(speed_ref), .force_ref_in(force_ref_in),
    .pos_err(pos_err), .ff_term(ff_term), .p_only(p_only), .force_ref_out(force_ref_out),
    .ctrl_tick(ctrl_tick));
  scac_ctrl_model mdl_u (.sys_clk(sys_clk), .rst_n(rst_n), .ctrl_tick(ctrl_tick),
    .cmd_mode(cmd_mode), .cmd_speed(cmd_speed), .cmd_step(cmd_step), .cmd_force(cmd_force),
    .cmd_err(cmd_err), .cmd_ff(cmd_ff), .pos_ctrl_mode(pos_ctrl_mode),
    .pos_ref_speed(pos_ref_speed), .speed_ref(speed_ref), .force_ref_in(force_ref_in),
    .pos_err(pos_err));
  task summarize;
    $display("comparisons %0d mismatches %0d", compares, n_errors);
    if (n_errors == 0 && compares > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask
  task chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    compares++;
    if (seen !== exp) begin
      n_errors++;
      $display("unexpected %s: expected %h seen %h", nm, exp, seen);
    end
  endtask
  task bus(input logic wr_en, input logic [7:0] a, input logic [15:0] d, output logic [31:0] q);
    int n;
    @(posedge sys_clk);
    avs_address <= a;
    avs_writedata <= {16'h0, d};
    avs_write <= wr_en;
    avs_read <= !wr_en;
    n = 0;
    do begin
      @(posedge sys_clk);
      n++;
    end while (avs_waitrequest !== 1'b0);
    q = avs_readdata;
    avs_write <= 1'b0;
    avs_read <= 1'b0;
    chk("wait cycles", n, 32'h2);
  endtask
  task wr(input logic [7:0] a, input logic [15:0] d);
    logic [31:0] q;
    bus(1'b1, a, d, q);
  endtask
  task rd(input logic [7:0] a, output logic [31:0] q);
    bus(1'b0, a, 16'h0, q);
  endtask
  task ticks(input int n);
    repeat (n) @(posedge ctrl_tick);
    repeat (2) @(posedge sys_clk);
  endtask
  function automatic logic [15:0] exp_reg(int i, logic [15:0] v);
    return v < lo_v[i] ? lo_v[i] : (v > hi_v[i] ? hi_v[i] : v);
  endfunction
  function automatic int ab(int v);
    return v < 0 ? -v : v;
  endfunction
  function automatic logic exp_p(int c, int thr, int f, int s, int st, int pe, logic pm);
    case (c)
      0: return ab(f) > thr;
      1: return ab(s) > thr;
      2: return longint'(ab(st)) * 100000 > thr;
      3: return pm && ab(pe) > thr;
      default: return 1'b0;
    endcase
  endfunction
  initial begin
    #(60000 * 20);
    n_errors++;
    summarize;
  end
  initial begin
    logic [31:0] q;
    logic [15:0] v;
    int f, s, st, pe, thr;
    logic pm;
    rst_v = '{`SCAC_RST_FF_GAIN, `SCAC_RST_FF_FILTER_TC, `SCAC_RST_GAIN_APP_SELECT,
      `SCAC_RST_MS_FORCE_THR, `SCAC_RST_MS_SPEED_THR, `SCAC_RST_MS_ACCEL_THR,
      `SCAC_RST_MS_POSERR_THR, `SCAC_RST_FORCE_LAG_TC, `SCAC_RST_SECOND_LPF_FREQ,
      `SCAC_RST_SECOND_LPF_Q, `SCAC_RST_NOTCH_ENABLE_CFG};
    hi_v = '{`SCAC_MAX_FF_GAIN, `SCAC_MAX_FF_FILTER_TC, 16'hffff, `SCAC_MAX_MS_FORCE_THR,
      `SCAC_MAX_MS_SPEED_THR, `SCAC_MAX_MS_ACCEL_THR, `SCAC_MAX_MS_POSERR_THR, 16'hffff,
      `SCAC_MAX_SECOND_LPF_FREQ, `SCAC_MAX_SECOND_LPF_Q, 16'hffff};
    lo_v = '{16'h0, 16'h0, 16'h0, 16'h0, 16'h0, 16'h0, 16'h0, 16'h0,
      `SCAC_MIN_SECOND_LPF_FREQ, `SCAC_MIN_SECOND_LPF_Q, 16'h0};
    void'($urandom(54279));
    repeat (10) @(posedge sys_clk);
    rst_n <= 1'b1;
    for (int i = 0; i < 11; i++) begin
      rd(8'(i * 4), q);
      chk("reset value", q, {16'h0, rst_v[i]});
    end
    for (int i = 0; i < 10; i++)
      for (int k = 0; k < 3 && i != 2; k++) begin
        v = (k == 0) ? 16'($urandom) : ((k == 1) ? hi_v[i] + 16'h1 : 16'h0);
        wr(8'(i * 4), v);
        rd(8'(i * 4), q);
        chk("setting", q, {16'h0, exp_reg(i, v)});
      end
    wr(8'h30, 16'h1234);
    rd(8'h30, q);
    chk("unmapped", q, 32'h0);
    $display("test registers done");
    wr(`SCAC_OFS_FF_FILTER_TC, 16'h0);
    cmd_ff <= 1000;
    for (int g = 0; g <= 80; g += 40) begin
      wr(`SCAC_OFS_FF_GAIN, 16'(g));
      ticks(5);
      chk("ff_term", ff_term, 32'(1000 * g / 100));
    end
    wr(`SCAC_OFS_FF_FILTER_TC, 16'h1900);
    cmd_ff <= 2000;
    ticks(3);
    chk("ff smoothing", {31'h0, ff_term < 1600}, 32'h1);
    $display("test feedforward done");
    wr(`SCAC_OFS_FORCE_LAG_TC, 16'h0);
    wr(`SCAC_OFS_SECOND_LPF_FREQ, 16'h1388);
    wr(`SCAC_OFS_NOTCH_ENABLE_CFG, 16'h0);
    f = int'($urandom_range(0, 10000)) - 5000;
    cmd_force <= f;
    ticks(6);
    chk("force path", force_ref_out, f);
    wr(`SCAC_OFS_SECOND_LPF_FREQ, 16'h0064);
    cmd_force <= f + 20000;
    ticks(6);
    chk("lpf active", {31'h0, force_ref_out != f + 20000}, 32'h1);
    wr(`SCAC_OFS_SECOND_LPF_FREQ, 16'h1388);
    wr(`SCAC_OFS_FORCE_LAG_TC, 16'h0064);
    cmd_force <= f + 4000;
    ticks(3);
    chk("force lag", {31'h0, force_ref_out != f + 4000}, 32'h1);
    for (int k = 0; k < 4; k++) begin
      wr(`SCAC_OFS_NOTCH_ENABLE_CFG, (k == 0) ? 16'h0001 : ((k == 1) ? 16'h0100 : 16'h0010));
      rd(`SCAC_OFS_STATUS, q);
      chk("notch status", {31'h0, q[1]}, {31'h0, k < 2});
    end
    $display("test force chain done");
    for (int c = 0; c < 5; c++) begin
      wr(`SCAC_OFS_GAIN_APP_SELECT, 16'(c));
      thr = (c < 4) ? int'($urandom_range(0, hi_v[3 + c])) : 0;
      if (c < 4)
        wr(8'(12 + 4 * c), 16'(thr));
      for (int k = 0; k < 3; k++) begin
        f = k ? int'($urandom_range(0, 1600)) - 800 : thr;
        s = k ? int'($urandom_range(0, 40000)) - 20000 : thr;
        pe = k ? int'($urandom_range(0, 40000)) - 20000 : thr;
        st = (c == 2) ? int'($urandom_range(0, 1)) : 0;
        pm = k ? 1'($urandom_range(0, 1)) : 1'b1;
        cmd_force <= f;
        cmd_speed <= s;
        cmd_err <= pe;
        cmd_step <= st;
        cmd_mode <= pm;
        ticks(3);
        chk("p_only", {31'h0, p_only}, {31'h0, exp_p(c, thr, f, s, st, pe, pm)});
        rd(`SCAC_OFS_STATUS, q);
        chk("status mode", {31'h0, q[0]}, {31'h0, exp_p(c, thr, f, s, st, pe, pm)});
      end
    end
    $display("test mode switch done");
    summarize;
  end
endmodule // scac_adjust_chain_tb
bind scac_adjust_chain scac_chain_props chk_u (.sys_clk(sys_clk), .rst_n(rst_n),
  .avs_address(avs_address), .avs_read(avs_read), .avs_write(avs_write),
  .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest), .ff_term(ff_term),
  .p_only(p_only), .force_ref_out(force_ref_out), .ctrl_tick(ctrl_tick));
